/* src/acfg_defines.vh */
/*
 register offsets, field positions, reset values and codes of the
 accelerometer configuration bank.
 assumes inclusion by bare name from the design files.
*/
`ifndef ACFG_DEFINES_VH
`define ACFG_DEFINES_VH

`define ACFG_ADDR_OFS_X_LOW   8'h10
`define ACFG_ADDR_OFS_X_HIGH  8'h11
`define ACFG_ADDR_OFS_Y_LOW   8'h12
`define ACFG_ADDR_OFS_Y_HIGH  8'h13
`define ACFG_ADDR_OFS_Z_LOW   8'h14
`define ACFG_ADDR_OFS_Z_HIGH  8'h15
`define ACFG_ADDR_MODE        8'h16
`define ACFG_ADDR_CLEAR       8'h17
`define ACFG_ADDR_DETECT      8'h18
`define ACFG_ADDR_SOURCE      8'h0A
`define ACFG_ADDR_WINDOW      8'h1E

`define ACFG_RESET_BYTE       8'h00
`define ACFG_HIGH_MASK        8'h07
`define ACFG_MODE_MASK        8'h7F
`define ACFG_CLEAR_MASK       8'h03

`define ACFG_MODE_LSB         0
`define ACFG_RANGE_LSB        2
`define ACFG_SELF_TEST_BIT    4
`define ACFG_THREE_WIRE_BIT   5
`define ACFG_READY_DIS_BIT    6

`define ACFG_CLR_ONE_BIT      0
`define ACFG_CLR_TWO_BIT      1

`define ACFG_PIN_SWAP_BIT     0
`define ACFG_ROUTE_LSB        1
`define ACFG_X_DIS_BIT        3
`define ACFG_Y_DIS_BIT        4
`define ACFG_Z_DIS_BIT        5
`define ACFG_THR_FMT_BIT      6
`define ACFG_FILTER_BIT       7

`define ACFG_MODE_STANDBY     2'b00
`define ACFG_MODE_MEASURE     2'b01
`define ACFG_MODE_LEVEL       2'b10
`define ACFG_MODE_PULSE       2'b11

`define ACFG_RANGE_8G         2'b00
`define ACFG_RANGE_2G         2'b01
`define ACFG_RANGE_4G         2'b10

`define ACFG_ROUTE_LEVEL_ONE  2'b00
`define ACFG_ROUTE_PULSE_ONE  2'b01
`define ACFG_ROUTE_DOUBLE     2'b10

`endif

/* src/acfg_trim_reg.v */
/*
 one axis of 11-bit two's-complement offset trim, split in a low byte
 and a high register whose three low bits carry bits 10..8.
 assumes a decoded write strobe from the register port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "acfg_defines.vh"

module acfg_trim_reg (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        wr_low_i,
	input  wire        wr_high_i,
	input  wire [7:0]  wdata_i,
	output wire [7:0]  low_rd_o,
	output wire [7:0]  high_rd_o,
	output wire [10:0] trim_o
);
	reg [7:0] low_byte;
	reg [2:0] high_bits;

	// bit 0 weighs half a count, doubling to 64 counts at bit 7
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_byte  <= `ACFG_RESET_BYTE;
			high_bits <= 3'h0;
		end else begin
			if (wr_low_i) begin
				low_byte <= wdata_i;
			end
			if (wr_high_i) begin
				high_bits <= wdata_i[2:0];
			end
		end
	end

	assign low_rd_o  = low_byte;
	assign high_rd_o = {5'h00, high_bits} & `ACFG_HIGH_MASK;
	// bit 10 is the sign, 9 and 8 weigh 256 and 128 counts
	assign trim_o    = {high_bits, low_byte};
endmodule // acfg_trim_reg

`default_nettype wire

/* src/acfg_event_flags.v */
/*
 latched detection flags of one interrupt group: three axis hits and
 the group's own interrupt flag.
 assumes one-cycle hit pulses from the detector and one-cycle clears.
*/
`timescale 1ns/10ps
`default_nettype none

module acfg_event_flags (
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire [2:0] hit_i,
	input  wire [2:0] axis_en_i,
	input  wire       clear_i,
	output reg  [2:0] axis_flag_o,
	output reg        any_flag_o
);
	wire [2:0] hit_gated;

	assign hit_gated = hit_i & axis_en_i;

	// set wins over a clear arriving in the same cycle
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			axis_flag_o <= 3'h0;
			any_flag_o  <= 1'b0;
		end else begin
			axis_flag_o <= (clear_i ? 3'h0 : axis_flag_o) | hit_gated;
			any_flag_o  <= (clear_i ? 1'b0 : any_flag_o) | (|hit_gated);
		end
	end
endmodule // acfg_event_flags

`default_nettype wire

/* src/acfg_bank.v */
/*
 configuration register bank of a three-axis accelerometer: offset
 trims, mode control, latch clear, detection control and the latched
 detection source with routing onto the two interrupt pins.
 assumes a synchronous byte register port from the serial front end and
 one-cycle hit pulses from the detection engines.
*/
`timescale 1ns/10ps
`default_nettype none
`include "acfg_defines.vh"

module acfg_bank (
	input  wire        CLK_SYS_I,
	input  wire        RST_N_I,
	input  wire        REG_WR_I,
	input  wire        REG_RD_I,
	input  wire [7:0]  REG_ADDR_I,
	input  wire [7:0]  REG_WDATA_I,
	input  wire [7:0]  SECOND_WINDOW_I,
	input  wire        SAMPLE_READY_I,
	input  wire [2:0]  LEVEL_HIT_I,
	input  wire [2:0]  PULSE_HIT_I,
	input  wire [2:0]  DOUBLE_HIT_I,
	output reg  [7:0]  REG_RDATA_O,
	output reg  [10:0] X_OFFSET_TRIM_O,
	output reg  [10:0] Y_OFFSET_TRIM_O,
	output reg  [10:0] Z_OFFSET_TRIM_O,
	output reg  [1:0]  OP_MODE_O,
	output reg  [1:0]  RANGE_SELECT_O,
	output reg         SELF_TEST_ON_O,
	output reg         THREE_WIRE_SELECT_O,
	output reg         THRESHOLD_FORMAT_SELECT_O,
	output reg         FILTER_BANDWIDTH_SELECT_O,
	output reg  [2:0]  AXIS_ENABLE_O,
	output reg         DETECT_RESTART_O,
	output reg         EVENT_ONE_PIN_O,
	output reg         EVENT_TWO_PIN_O
);
	reg  [7:0]  mode_reg;
	reg  [7:0]  detect_reg;
	reg  [7:0]  next_rdata;
	reg         clr_one;
	reg         clr_two;
	reg  [2:0]  one_hit;
	reg  [2:0]  two_hit;
	reg  [2:0]  level_set;
	reg  [2:0]  pulse_set;
	reg         level_clr;
	reg         pulse_clr;
	reg         event_one;
	reg         event_two;
	wire [7:0]  x_low_rd;
	wire [7:0]  x_high_rd;
	wire [7:0]  y_low_rd;
	wire [7:0]  y_high_rd;
	wire [7:0]  z_low_rd;
	wire [7:0]  z_high_rd;
	wire [10:0] x_trim;
	wire [10:0] y_trim;
	wire [10:0] z_trim;
	wire [2:0]  level_flag;
	wire [2:0]  pulse_flag;
	wire        level_any;
	wire        pulse_any;
	wire [1:0]  route;
	wire [2:0]  axis_en;
	wire        wr_clear;
	wire        single_window;
	wire [2:0]  two_source;

	assign route    = detect_reg[`ACFG_ROUTE_LSB +: 2];
	assign axis_en  = ~{detect_reg[`ACFG_Z_DIS_BIT],
		detect_reg[`ACFG_Y_DIS_BIT], detect_reg[`ACFG_X_DIS_BIT]};
	assign wr_clear = REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_CLEAR);
	// a zero second-pulse window degrades the second flag to single pulses
	assign single_window = (SECOND_WINDOW_I == 8'h00);
	assign two_source    = single_window ? PULSE_HIT_I : DOUBLE_HIT_I;

	acfg_trim_reg u_trim_x (
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (RST_N_I),
		.wr_low_i  (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_OFS_X_LOW)),
		.wr_high_i (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_OFS_X_HIGH)),
		.wdata_i   (REG_WDATA_I),
		.low_rd_o  (x_low_rd),
		.high_rd_o (x_high_rd),
		.trim_o    (x_trim)
	);

	acfg_trim_reg u_trim_y (
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (RST_N_I),
		.wr_low_i  (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_OFS_Y_LOW)),
		.wr_high_i (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_OFS_Y_HIGH)),
		.wdata_i   (REG_WDATA_I),
		.low_rd_o  (y_low_rd),
		.high_rd_o (y_high_rd),
		.trim_o    (y_trim)
	);

	acfg_trim_reg u_trim_z (
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (RST_N_I),
		.wr_low_i  (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_OFS_Z_LOW)),
		.wr_high_i (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_OFS_Z_HIGH)),
		.wdata_i   (REG_WDATA_I),
		.low_rd_o  (z_low_rd),
		.high_rd_o (z_high_rd),
		.trim_o    (z_trim)
	);

	// control registers
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mode_reg   <= `ACFG_RESET_BYTE;
			detect_reg <= `ACFG_RESET_BYTE;
		end else begin
			if (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_MODE)) begin
				mode_reg <= REG_WDATA_I & `ACFG_MODE_MASK;
			end
			if (REG_WR_I && (REG_ADDR_I == `ACFG_ADDR_DETECT)) begin
				detect_reg <= REG_WDATA_I;
			end
		end
	end

	// clear strobes steered by the routing field
	always @* begin
		clr_one = wr_clear && REG_WDATA_I[`ACFG_CLR_ONE_BIT];
		clr_two = wr_clear && REG_WDATA_I[`ACFG_CLR_TWO_BIT];
		level_clr = 1'b0;
		pulse_clr = 1'b0;
		one_hit   = 3'h0;
		two_hit   = 3'h0;
		level_set = LEVEL_HIT_I;
		pulse_set = PULSE_HIT_I;
		case (route)
		`ACFG_ROUTE_LEVEL_ONE: begin
			level_clr = clr_one;
			pulse_clr = clr_two;
		end
		`ACFG_ROUTE_PULSE_ONE: begin
			pulse_clr = clr_one;
			level_clr = clr_two;
		end
		`ACFG_ROUTE_DOUBLE: begin
			// first clear is ignored here; the second clears both
			level_set = 3'h0;
			pulse_set = PULSE_HIT_I | two_source;
			pulse_clr = clr_two;
			level_clr = clr_two;
		end
		default: begin
			// undefined routing latches nothing; clears still act as routing 00
			level_set = 3'h0;
			pulse_set = 3'h0;
			level_clr = clr_one;
			pulse_clr = clr_two;
		end
		endcase
		one_hit = PULSE_HIT_I & axis_en;
		two_hit = two_source & axis_en;
	end

	acfg_event_flags u_level (
		.clk_i       (CLK_SYS_I),
		.rst_n_i     (RST_N_I),
		.hit_i       (level_set),
		.axis_en_i   (axis_en),
		.clear_i     (level_clr),
		.axis_flag_o (level_flag),
		.any_flag_o  (level_any)
	);

	acfg_event_flags u_pulse (
		.clk_i       (CLK_SYS_I),
		.rst_n_i     (RST_N_I),
		.hit_i       (pulse_set),
		.axis_en_i   (axis_en),
		.clear_i     (pulse_clr),
		.axis_flag_o (pulse_flag),
		.any_flag_o  (pulse_any)
	);

	// interrupt flags per routing; set wins over clear
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			event_one <= 1'b0;
			event_two <= 1'b0;
		end else begin
			case (route)
			`ACFG_ROUTE_LEVEL_ONE: begin
				event_one <= (clr_one ? 1'b0 : event_one) | (|(LEVEL_HIT_I & axis_en));
				event_two <= (clr_two ? 1'b0 : event_two) | (|(PULSE_HIT_I & axis_en));
			end
			`ACFG_ROUTE_PULSE_ONE: begin
				event_one <= (clr_one ? 1'b0 : event_one) | (|(PULSE_HIT_I & axis_en));
				event_two <= (clr_two ? 1'b0 : event_two) | (|(LEVEL_HIT_I & axis_en));
			end
			`ACFG_ROUTE_DOUBLE: begin
				event_one <= (clr_two ? 1'b0 : event_one) | (|one_hit);
				event_two <= (clr_two ? 1'b0 : event_two) | (|two_hit);
			end
			default: begin
				event_one <= clr_one ? 1'b0 : event_one;
				event_two <= clr_two ? 1'b0 : event_two;
			end
			endcase
		end
	end

	// read mux; unmapped offsets answer zero
	always @* begin
		case (REG_ADDR_I)
		`ACFG_ADDR_OFS_X_LOW:  next_rdata = x_low_rd;
		`ACFG_ADDR_OFS_X_HIGH: next_rdata = x_high_rd;
		`ACFG_ADDR_OFS_Y_LOW:  next_rdata = y_low_rd;
		`ACFG_ADDR_OFS_Y_HIGH: next_rdata = y_high_rd;
		`ACFG_ADDR_OFS_Z_LOW:  next_rdata = z_low_rd;
		`ACFG_ADDR_OFS_Z_HIGH: next_rdata = z_high_rd;
		`ACFG_ADDR_MODE:       next_rdata = mode_reg;
		`ACFG_ADDR_CLEAR:      next_rdata = `ACFG_RESET_BYTE;
		`ACFG_ADDR_DETECT:     next_rdata = detect_reg;
		`ACFG_ADDR_SOURCE: begin
			next_rdata = {level_flag[0], level_flag[1], level_flag[2],
				pulse_flag[0], pulse_flag[1], pulse_flag[2],
				event_two, event_one};
		end
		default:               next_rdata = `ACFG_RESET_BYTE;
		endcase
	end

	// registered outputs, one cycle behind the register state
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			REG_RDATA_O               <= `ACFG_RESET_BYTE;
			X_OFFSET_TRIM_O           <= 11'h000;
			Y_OFFSET_TRIM_O           <= 11'h000;
			Z_OFFSET_TRIM_O           <= 11'h000;
			OP_MODE_O                 <= `ACFG_MODE_STANDBY;
			RANGE_SELECT_O            <= `ACFG_RANGE_8G;
			SELF_TEST_ON_O            <= 1'b0;
			THREE_WIRE_SELECT_O       <= 1'b0;
			THRESHOLD_FORMAT_SELECT_O <= 1'b0;
			FILTER_BANDWIDTH_SELECT_O <= 1'b0;
			AXIS_ENABLE_O             <= 3'h7;
			DETECT_RESTART_O          <= 1'b0;
			EVENT_ONE_PIN_O           <= 1'b0;
			EVENT_TWO_PIN_O           <= 1'b0;
		end else begin
			if (REG_RD_I) begin
				REG_RDATA_O <= next_rdata;
			end
			X_OFFSET_TRIM_O           <= x_trim;
			Y_OFFSET_TRIM_O           <= y_trim;
			Z_OFFSET_TRIM_O           <= z_trim;
			OP_MODE_O                 <= mode_reg[`ACFG_MODE_LSB +: 2];
			RANGE_SELECT_O            <= mode_reg[`ACFG_RANGE_LSB +: 2];
			SELF_TEST_ON_O            <= mode_reg[`ACFG_SELF_TEST_BIT];
			THREE_WIRE_SELECT_O       <= mode_reg[`ACFG_THREE_WIRE_BIT];
			THRESHOLD_FORMAT_SELECT_O <= detect_reg[`ACFG_THR_FMT_BIT];
			FILTER_BANDWIDTH_SELECT_O <= detect_reg[`ACFG_FILTER_BIT];
			AXIS_ENABLE_O             <= axis_en;
			DETECT_RESTART_O          <= (route == `ACFG_ROUTE_DOUBLE) && clr_two;
			// first pin also carries sample-ready unless hidden
			if (detect_reg[`ACFG_PIN_SWAP_BIT]) begin
				EVENT_ONE_PIN_O <= event_two | (SAMPLE_READY_I
					& ~mode_reg[`ACFG_READY_DIS_BIT]);
				EVENT_TWO_PIN_O <= event_one;
			end else begin
				EVENT_ONE_PIN_O <= event_one | (SAMPLE_READY_I
					& ~mode_reg[`ACFG_READY_DIS_BIT]);
				EVENT_TWO_PIN_O <= event_two;
			end
		end
	end
endmodule // acfg_bank

`default_nettype wire

/* tb/acfg_bank_asserts.sv */
/*
 timing checks of the accelerometer configuration bank.
 bound to acfg_bank; sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module acfg_bank_chk (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_N_I,
	input wire logic        REG_WR_I,
	input wire logic        REG_RD_I,
	input wire logic [7:0]  REG_ADDR_I,
	input wire logic [7:0]  REG_WDATA_I,
	input wire logic [7:0]  REG_RDATA_O,
	input wire logic [10:0] X_OFFSET_TRIM_O,
	input wire logic [10:0] Y_OFFSET_TRIM_O,
	input wire logic [1:0]  OP_MODE_O,
	input wire logic [1:0]  RANGE_SELECT_O,
	input wire logic        SELF_TEST_ON_O,
	input wire logic        THREE_WIRE_SELECT_O,
	input wire logic        FILTER_BANDWIDTH_SELECT_O,
	input wire logic [2:0]  AXIS_ENABLE_O,
	input wire logic        DETECT_RESTART_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	wire w16 = REG_WR_I && REG_ADDR_I == 8'h16;
	wire w18 = REG_WR_I && REG_ADDR_I == 8'h18;
	mode_field_a: assert property (w16 |-> ##2 OP_MODE_O == $past(REG_WDATA_I[1:0], 2)
		&& RANGE_SELECT_O == $past(REG_WDATA_I[3:2], 2)) else $error("mode or range wrong");
	test_wire_a: assert property (w16 |-> ##2 SELF_TEST_ON_O == $past(REG_WDATA_I[4], 2)
		&& THREE_WIRE_SELECT_O == $past(REG_WDATA_I[5], 2)) else $error("self-test or wire bad");
	axis_enable_a: assert property (w18 |-> ##2 AXIS_ENABLE_O == ~$past(REG_WDATA_I[5:3], 2))
		else $error("axis enable wrong");
	filter_bw_a: assert property (w18 |-> ##2 FILTER_BANDWIDTH_SELECT_O == $past(REG_WDATA_I[7], 2))
		else $error("filter select wrong");
	x_trim_low_a: assert property (REG_WR_I && REG_ADDR_I == 8'h10
		|-> ##2 X_OFFSET_TRIM_O[7:0] == $past(REG_WDATA_I, 2)) else $error("x trim low wrong");
	y_trim_high_a: assert property (REG_WR_I && REG_ADDR_I == 8'h13
		|-> ##2 Y_OFFSET_TRIM_O[10:8] == $past(REG_WDATA_I[2:0], 2)) else $error("y trim high bad");
	restart_pulse_a: assert property (DETECT_RESTART_O |=> !DETECT_RESTART_O)
		else $error("restart longer than one cycle");
	mode_top_a: assert property (REG_RD_I && REG_ADDR_I == 8'h16 |=> !REG_RDATA_O[7])
		else $error("mode bit 7 reads set");
	rdata_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
		else $error("read data moved without read");
endmodule // acfg_bank_chk
bind acfg_bank acfg_bank_chk acfg_bank_chk_i (.*);
`default_nettype wire

/* tb/acfg_host.sv */
/*
 host model driving the byte register port.
 assumes one-cycle strobes; idle address and data show junk.
*/
`timescale 1ns/10ps
`default_nettype none
module acfg_host (
	input  wire logic       clk_i,
	output var  logic       wr_o,
	output var  logic       rd_o,
	output var  logic [7:0] addr_o,
	output var  logic [7:0] wdata_o,
	input  wire logic [7:0] rdata_i
);
	initial begin
		wr_o = 0;
		rd_o = 0;
		addr_o = 8'hA5;
		wdata_o = 8'h5A;
	end
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		#1;
		wr_o = 1;
		addr_o = a;
		wdata_o = d;
		@(posedge clk_i);
		#1;
		wr_o = 0;
		// released bus shows inverse so stale values never look valid
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		rd_o = 1;
		addr_o = a;
		@(posedge clk_i);
		#1;
		d = rdata_i;
		rd_o = 0;
		addr_o = ~a;
	endtask
endmodule // acfg_host
`default_nettype wire

/* tb/testbench.sv */
/*
 self-checking bench of acfg_bank.
 host model drives registers; hit pulses come from here.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        ready = 0;
	logic [7:0]  window = 0;
	logic [2:0]  lvl = 0, pls = 0, dbl = 0;
	logic        wr, rd, st, tw, thr, fbw, rstp, pin1, pin2;
	logic [7:0]  addr, wdata, rdata, d;
	logic [10:0] xt, yt, zt;
	logic [1:0]  mode, rng;
	logic [2:0]  axen;
	int          failures = 0, n_tests = 0, restarts = 0;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
	always #5 clk = ~clk;
	always @(posedge clk) if (rstp === 1'b1) restarts++;
	acfg_host host_i (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
		.rdata_i(rdata));
	acfg_bank acfg_bank_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .SECOND_WINDOW_I(window),
		.SAMPLE_READY_I(ready), .LEVEL_HIT_I(lvl), .PULSE_HIT_I(pls), .DOUBLE_HIT_I(dbl),
		.REG_RDATA_O(rdata), .X_OFFSET_TRIM_O(xt), .Y_OFFSET_TRIM_O(yt),
		.Z_OFFSET_TRIM_O(zt), .OP_MODE_O(mode), .RANGE_SELECT_O(rng), .SELF_TEST_ON_O(st),
		.THREE_WIRE_SELECT_O(tw), .THRESHOLD_FORMAT_SELECT_O(thr),
		.FILTER_BANDWIDTH_SELECT_O(fbw), .AXIS_ENABLE_O(axen), .DETECT_RESTART_O(rstp),
		.EVENT_ONE_PIN_O(pin1), .EVENT_TWO_PIN_O(pin2));
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic wrs(input logic [7:0] a, v);
		host_i.wr(a, v);
		tick;
	endtask
	task automatic rchk(input logic [7:0] a, e);
		host_i.rd(a, d);
		`CHK(d, e)
	endtask
	task automatic hit(input logic [2:0] l, p, b);
		tick;
		lvl = l;
		pls = p;
		dbl = b;
		tick;
		lvl = 0;
		pls = 0;
		dbl = 0;
		tick;
	endtask
	task automatic t_reset;
		for (int a = 16; a < 25; a++)
			rchk(8'(a), 8'h00);
		rchk(8'h0A, 8'h00);
		`CHK(axen, 3'b111)
	endtask
	task automatic t_trim;
		wrs(8'h10, 8'h81);
		wrs(8'h11, 8'hFD);
		wrs(8'h12, 8'h7E);
		wrs(8'h13, 8'h02);
		wrs(8'h15, 8'h04);
		`CHK(xt, 11'h581)
		`CHK(yt, 11'h27E)
		`CHK(zt, 11'h400)
		rchk(8'h11, 8'h05);
		rchk(8'h12, 8'h7E);
	endtask
	task automatic t_mode;
		for (int k = 0; k < 12; k++) begin
			wrs(8'h16, {2'b11, k[3], k[2], k[3:2], k[1:0]});
			`CHK(mode, k[1:0])
			`CHK(rng, k[3:2])
			`CHK(st, k[2])
			`CHK(tw, k[3])
			rchk(8'h16, {2'b01, k[3], k[2], k[3:2], k[1:0]});
		end
	endtask
	task automatic t_ready;
		wrs(8'h16, 8'h00);
		ready = 1;
		tick;
		tick;
		`CHK(pin1, 1'b1)
		wrs(8'h16, 8'h40);
		tick;
		`CHK(pin1, 1'b0)
		ready = 0;
	endtask
	task automatic t_routes;
		wrs(8'h18, 8'h00);
		hit(3'b001, 3'b000, 3'b000);
		`CHK({pin1, pin2}, 2'b10)
		hit(3'b000, 3'b100, 3'b000);
		wrs(8'h17, 8'h00);
		rchk(8'h0A, 8'h87);
		wrs(8'h17, 8'h01);
		rchk(8'h0A, 8'h06);
		wrs(8'h17, 8'h02);
		rchk(8'h0A, 8'h00);
		wrs(8'h18, 8'h02);
		hit(3'b010, 3'b000, 3'b000);
		`CHK({pin1, pin2}, 2'b01)
		rchk(8'h0A, 8'h42);
		wrs(8'h18, 8'h01);
		`CHK({pin1, pin2}, 2'b10)
		wrs(8'h17, 8'h02);
		hit(3'b001, 3'b000, 3'b000);
		`CHK({pin1, pin2}, 2'b01)
		wrs(8'h17, 8'h01);
		rchk(8'h0A, 8'h00);
	endtask
	task automatic t_axis;
		wrs(8'h18, 8'h08);
		`CHK(axen, 3'b110)
		hit(3'b001, 3'b000, 3'b000);
		rchk(8'h0A, 8'h00);
		wrs(8'h18, 8'h06);
		hit(3'b001, 3'b001, 3'b001);
		rchk(8'h0A, 8'h00);
		wrs(8'h18, 8'hC0);
		`CHK({thr, fbw, axen}, 5'h1F)
	endtask
	task automatic t_double;
		wrs(8'h18, 8'h04);
		restarts = 0;
		hit(3'b000, 3'b001, 3'b000);
		rchk(8'h0A, 8'h13);
		wrs(8'h17, 8'h01);
		rchk(8'h0A, 8'h13);
		wrs(8'h17, 8'h02);
		rchk(8'h0A, 8'h00);
		`CHK(restarts, 1)
		window = 8'h05;
		hit(3'b000, 3'b001, 3'b000);
		host_i.rd(8'h0A, d);
		`CHK(d[1:0], 2'b01)
		hit(3'b000, 3'b000, 3'b001);
		host_i.rd(8'h0A, d);
		`CHK(d[1:0], 2'b11)
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1;
		t_reset;
		t_trim;
		t_mode;
		t_ready;
		t_routes;
		t_axis;
		t_double;
		close_out;
	end
	// run needs about 200 cycles; generous margin
	initial begin
		#100000;
		failures++;
		close_out;
	end
endmodule // testbench
`default_nettype wire
